// >>> rtl/sdf_decim_filter.sv
// Purpose: filter_order_select/sinc4 decimation filter with chop and zero latency
// Assumes: modulator bit synchronous to mclk
// Notes: results land in an 8-word FIFO read over AHB-Lite
`timescale 1ns/1ns
`include "sdf_map.svh"
module sdf_decim_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // modulator side
  input wire logic modBit,
  output logic modReset_q,
  output logic chopSwap_q,
  // ready pin
  output logic rdyN_q,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  localparam int ACC = `SDF_ACC_W;
  localparam int NS = `SDF_NSTG;
  localparam int RW = `SDF_RES_W;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  sdf_pkg::sdf_ctrl_t ctrl_q;
  sdf_pkg::sdf_stat_t stat;
  sdf_pkg::sdf_ahb_ph_t ph_q;
  sdf_pkg::sdf_state_t state_q;
  logic selPh;
  logic ctrlWr;
  logic dataRd;
  logic [31:0] rdWord;
  logic [RW-1:0] fifoData;
  logic fifoInReady;
  logic fifoOutValid;
  logic [3:0] fifoLevel;
  logic restart;

  assign selPh = hsel & hready & htrans[1];
  assign ctrlWr = ph_q.wr & (ph_q.addr == `SDF_OFF_CTRL);
  assign dataRd = selPh & ~hwrite & (haddr[7:0] == `SDF_OFF_DATA);
  assign restart = ctrlWr;
  assign rdWord = (haddr[7:0] == `SDF_OFF_CTRL) ? {16'h0000, ctrl_q} :
                  (haddr[7:0] == `SDF_OFF_STAT) ? {24'h000000, stat} :
                  (haddr[7:0] == `SDF_OFF_DATA) ? fifoData : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ph_q <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_q <= '{wr: selPh & hwrite, addr: haddr[7:0]};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (selPh & ~hwrite) begin
        hrdata <= rdWord;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= sdf_pkg::sdf_ctrl_t'(`SDF_CTRL_RST);
    end else if (ctrlWr) begin
      ctrl_q <= sdf_pkg::sdf_ctrl_t'(hwdata[`SDF_CTRL_W-1:0]);
    end
  end

  // ----------------------------------------
  // rate and stage selection
  // ----------------------------------------
  logic [9:0] fsEff;
  logic [2:0] nStg;
  logic [19:0] decLast;
  logic [19:0] snapPt;
  logic [5:0] shiftAmt;
  logic perConv;

  // divider zero treated as one
  assign fsEff = (ctrl_q.rateDivider == 10'h000) ? 10'h001 : ctrl_q.rateDivider;
  assign nStg = (ctrl_q.orderSel ? `SDF_ORD3 : `SDF_ORD4) + {2'b00, ctrl_q.notch60};
  assign decLast = {fsEff, `SDF_DEC_BITS'(0)} - 20'h00001;
  assign snapPt = 20'({10'h000, fsEff} * `SDF_SNAP_MUL);
  assign shiftAmt = 6'({3'h0, nStg} * `SDF_SHIFT_STEP);
  assign perConv = ctrl_q.chopEn | ctrl_q.zeroLat;

  // ----------------------------------------
  // decimation timing
  // ----------------------------------------
  logic ce;
  logic tick;
  logic convDone;
  logic filtClr;
  logic push;
  logic half_q;
  logic [19:0] divCnt_q;
  logic [2:0] tickCnt_q;
  logic [2:0] tickNext;

  // a full FIFO stalls the whole datapath
  assign ce = fifoInReady;
  assign tick = ce & (divCnt_q == decLast);
  assign tickNext = tickCnt_q + 3'h1;
  assign convDone = tick & (tickNext >= nStg);
  assign filtClr = restart | (convDone & perConv);
  assign push = convDone & ~(ctrl_q.chopEn & ~half_q);

  always_ff @(posedge mclk) begin
    if (sys_rst | restart) begin
      divCnt_q <= 20'h00000;
    end else if (ce) begin
      divCnt_q <= tick ? 20'h00000 : divCnt_q + 20'h00001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst | filtClr) begin
      tickCnt_q <= 3'h0;
    end else if (tick & ~convDone) begin
      tickCnt_q <= tickNext;
    end
  end

  // ----------------------------------------
  // integrators
  // ----------------------------------------
  logic [ACC-1:0] sIn;
  logic [ACC-1:0] intOut [NS];
  logic [ACC-1:0] intLast;
  logic [ACC-1:0] snap_q;

  // +1 or -1; swapped phase undone after the combs
  assign sIn = {{(ACC-1){~modBit}}, 1'b1};

  for (genvar k = 0; k < NS; k++) begin : g_int
    logic [ACC-1:0] acc_q;
    logic [ACC-1:0] src;
    if (k == 0) begin : g_first
      assign src = sIn;
    end else begin : g_next
      assign src = intOut[k-1];
    end
    assign intOut[k] = acc_q;
    always_ff @(posedge mclk) begin
      if (sys_rst | filtClr | (3'(k) >= nStg)) begin
        acc_q <= '0;
      end else if (ce) begin
        acc_q <= acc_q + src;
      end
    end
  end

  assign intLast = intOut[nStg - 3'h1];

  // 60 Hz window starts a sixth into the period
  always_ff @(posedge mclk) begin
    if (sys_rst | filtClr) begin
      snap_q <= '0;
    end else if (ce & (divCnt_q == snapPt)) begin
      snap_q <= intLast;
    end
  end

  // ----------------------------------------
  // combs at the decimation tick rate
  // ----------------------------------------
  logic [ACC-1:0] cIn [NS+1];
  logic [RW-1:0] rawRes;
  logic [ACC-1:0] rndBias;

  assign cIn[0] = intLast;

  for (genvar k = 0; k < NS; k++) begin : g_comb
    logic [ACC-1:0] prev_q;
    logic [ACC-1:0] ref_w;
    logic on;
    assign on = 3'(k) < nStg;
    assign ref_w = ((k == 0) && ctrl_q.notch60) ? snap_q : prev_q;
    assign cIn[k+1] = on ? cIn[k] - ref_w : cIn[k];
    always_ff @(posedge mclk) begin
      if (sys_rst | filtClr) begin
        prev_q <= '0;
      end else if (tick & on) begin
        prev_q <= cIn[k];
      end
    end
  end

  // round to nearest, a freshly cleared filter lands on the full code
  assign rndBias = {{(ACC-1){1'b0}}, 1'b1} << (shiftAmt - 6'h01);
  assign rawRes = RW'(($signed(cIn[NS]) + $signed(rndBias)) >>> shiftAmt);

  // ----------------------------------------
  // chop averaging
  // ----------------------------------------
  logic [RW-1:0] polRes;
  logic [RW-1:0] prevV_q;
  logic [RW:0] sumV;
  logic [RW-1:0] outRes;

  assign polRes = chopSwap_q ? RW'(-rawRes) : rawRes;
  assign sumV = {polRes[RW-1], polRes} + {prevV_q[RW-1], prevV_q};
  assign outRes = ctrl_q.chopEn ? sumV[RW:1] : rawRes;

  always_ff @(posedge mclk) begin
    if (sys_rst | restart) begin
      chopSwap_q <= 1'b0;
      half_q <= 1'b0;
      prevV_q <= '0;
    end else if (convDone & ctrl_q.chopEn) begin
      chopSwap_q <= ~chopSwap_q;
      half_q <= 1'b1;
      prevV_q <= polRes;
    end
  end

  // ----------------------------------------
  // settling state
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst | restart) begin
      state_q <= sdf_pkg::ST_SETTLING;
    end else begin
      case (state_q)
        sdf_pkg::ST_SETTLING: begin
          if (push) begin
            state_q <= sdf_pkg::ST_RUNNING;
          end
        end
        sdf_pkg::ST_RUNNING: begin
          state_q <= sdf_pkg::ST_RUNNING;
        end
        default: begin
          state_q <= sdf_pkg::ST_SETTLING;
        end
      endcase
    end
  end

  // ----------------------------------------
  // result FIFO and pins
  // ----------------------------------------
  sdf_fifo #(.W(RW), .DEPTH(`SDF_FIFO_D)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(restart),
    .inValid(push),
    .inReady(fifoInReady),
    .inData(outRes),
    .outValid(fifoOutValid),
    .outReady(dataRd),
    .outData(fifoData),
    .level(fifoLevel)
  );

  assign stat = '{stalled: ~fifoInReady, level: fifoLevel, chopPhase: chopSwap_q,
                  settled: state_q == sdf_pkg::ST_RUNNING, avail: fifoOutValid};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdyN_q <= 1'b1;
      modReset_q <= 1'b0;
    end else begin
      rdyN_q <= restart | ~fifoOutValid;
      modReset_q <= restart;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic [19:0] gapCnt_q;
  always_ff @(posedge mclk) begin
    if (sys_rst | restart | tick) begin
      gapCnt_q <= 20'h00000;
    end else if (ce) begin
      gapCnt_q <= gapCnt_q + 20'h00001;
    end
  end

  order_sel_a: assert property (ctrlWr && !hwdata[`SDF_CTRL_ORDER] && !hwdata[`SDF_CTRL_NOTCH]
    |=> nStg == 3'h4) else $error("order bit clear did not give four stages");
  dec_period_a: assert property (tick |-> gapCnt_q == decLast)
    else $error("decimation period is not 1024 times divider");
  first_settle_a: assert property (push && state_q == sdf_pkg::ST_SETTLING && !perConv
    |-> tickCnt_q == nStg - 3'h1) else $error("first result before filter settled");
  chop_swap_a: assert property (convDone && ctrl_q.chopEn && !restart
    |=> chopSwap_q != $past(chopSwap_q)) else $error("inputs not swapped after chop phase");
  chop_period_a: assert property (push && ctrl_q.chopEn |-> tickCnt_q == nStg - 3'h1)
    else $error("chop result not at end of full phase");
  chop_settle_a: assert property (push && ctrl_q.chopEn && state_q == sdf_pkg::ST_SETTLING
    |-> half_q) else $error("chop result before two phases");
  notch_stage_a: assert property (ctrl_q.notch60 |-> nStg == (ctrl_q.orderSel ? 3'h4 : 3'h5))
    else $error("notch stage missing");
  zl_clear_a: assert property (convDone && ctrl_q.zeroLat |=> tickCnt_q == 3'h0
    && g_int[0].acc_q == '0) else $error("zero latency did not restart filter");
  restart_rdy_a: assert property (ctrlWr |=> rdyN_q && modReset_q ##1 !modReset_q)
    else $error("ready not inactive after restart");
  cfg_restart_a: assert property (ctrlWr |=> divCnt_q == 20'h00000
    && state_q == sdf_pkg::ST_SETTLING) else $error("config write did not restart settling");

  chop_push_c: cover property (push && ctrl_q.chopEn);
  zl_push_c: cover property (push && ctrl_q.zeroLat);
  notch_push_c: cover property (push && ctrl_q.notch60);
  fifo_full_c: cover property (!fifoInReady);

endmodule : sdf_decim_filter

// >>> rtl/sdf_fifo.sv
// Purpose: result FIFO between filter and bus
// Assumes: DEPTH is a power of two
// Notes: flush empties it in one cycle
`timescale 1ns/1ns
module sdf_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8,
  localparam int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [AW:0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign inReady = cnt_q != (AW+1)'(DEPTH);
  assign outValid = cnt_q != '0;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr_q];
  assign level = cnt_q;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst | flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sdf_fifo

// >>> shared/sdf_map.svh
// Purpose: constants of the sinc decimation filter
// Assumes: 50 MHz mclk, AHB-Lite register access
// Notes: struct layouts in sdf_pkg
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SDF_OFF_CTRL 8'h00
`define SDF_OFF_STAT 8'h04
`define SDF_OFF_DATA 8'h08
`define SDF_CTRL_W 16
`define SDF_STAT_W 8
`define SDF_CTRL_RST 16'h0060
`define SDF_CTRL_ORDER 10
`define SDF_CTRL_NOTCH 12

// ----------------------------------------
// filter constants
// ----------------------------------------
`define SDF_MCLK_HZ 50000000
`define SDF_DEC_BITS 10
`define SDF_SHIFT_STEP 6'h0a
`define SDF_SNAP_MUL 20'h000ab
`define SDF_ACC_W 104
`define SDF_NSTG 5
`define SDF_ORD4 3'h4
`define SDF_ORD3 3'h3
`define SDF_RES_W 32
`define SDF_FIFO_D 8

`endif

// >>> shared/sdf_pkg.sv
// Purpose: types of the sinc decimation filter
// Assumes: layouts match sdf_map.svh widths
// Notes: none
package sdf_pkg;

  // control word, 16 bits
  typedef struct packed {
    logic [1:0] channel;
    logic zeroLat;
    logic notch60;
    logic chopEn;
    logic orderSel;
    logic [9:0] rateDivider;
  } sdf_ctrl_t;

  // status word, 8 bits
  typedef struct packed {
    logic stalled;
    logic [3:0] level;
    logic chopPhase;
    logic settled;
    logic avail;
  } sdf_stat_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } sdf_ahb_ph_t;

  typedef enum logic {ST_SETTLING, ST_RUNNING} sdf_state_t;

endpackage : sdf_pkg

// >>> verif/sdf_mod_model.sv
// Purpose: modulator stand-in driving a constant input level
// Assumes: the filter undoes the polarity swap itself
// Notes: level 1 means +1, level 0 means -1
`timescale 1ns/1ns
module sdf_mod_model (
  // level and swap
  input wire logic inLevel,
  input wire logic chopSwap,
  // bitstream
  output logic modBit
);
  // swapped inputs invert the bit
  assign modBit = inLevel ^ chopSwap;
endmodule : sdf_mod_model

// >>> verif/tb_sdf_decim_filter.sv
// Purpose: self-checking bench of the decimation filter
// Assumes: divider 1, constant modulator level
// Notes: random level and upper ctrl bits per config
`timescale 1ns/1ns
`include "sdf_map.svh"
module tb_sdf_decim_filter;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic inLevel = 1'b1;
  logic modBit, modReset_q, chopSwap_q, rdyN_q, hreadyout, hresp, hready;
  logic [31:0] hrdata, rd;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int tw, t1, t2, e;
  // sinc4, filter_order_select on channel 1, chop3 with notch, chop4, chop3, zero latency sinc4
  logic [15:0] cfg [6] = '{16'h0001, 16'h4401, 16'h1c01, 16'h0801, 16'h0c01, 16'h2001};

  sdf_decim_filter dut (.mclk(mclk), .sys_rst(sys_rst), .modBit(modBit), .modReset_q(modReset_q),
    .chopSwap_q(chopSwap_q), .rdyN_q(rdyN_q), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  sdf_mod_model model (.inLevel(inLevel), .chopSwap(chopSwap_q), .modBit(modBit));

  assign hready = hreadyout;
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  // ----------------------------------------
  // expectations and tasks
  // ----------------------------------------
  function automatic int n_stg(logic [15:0] c);
    return (c[10] ? 3 : 4) + c[12];
  endfunction : n_stg

  function automatic int exp_first(logic [15:0] c);
    return (c[11] ? 2 : 1) * n_stg(c) * 1024 * c[9:0];
  endfunction : exp_first

  function automatic int exp_per(logic [15:0] c);
    return (c[11] | c[13]) ? n_stg(c) * 1024 * c[9:0] : 1024 * c[9:0];
  endfunction : exp_per

  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("Error %0s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_rng(string nm, int lo, int hi, int g);
    n_tests++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("Error %0s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic wait_rdy(logic lvl, output int t);
    int k;
    k = 0;
    while (rdyN_q !== lvl && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    t = cyc;
  endtask : wait_rdy

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    #(90000 * 20);
    num_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h52e9));
    repeat (10) @(posedge mclk);
    chk("rdyN in reset", 32'h1, {31'h0, rdyN_q});
    sys_rst <= 1'b0;
    @(posedge mclk);
    ahb(1'b0, `SDF_OFF_CTRL, 32'h0, rd);
    chk("ctrl reset", `SDF_CTRL_RST, rd);
    ahb(1'b1, 8'h10, $urandom, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    foreach (cfg[i]) begin
      inLevel <= 1'($urandom_range(1));
      ahb(1'b1, `SDF_OFF_CTRL, {16'($urandom), cfg[i]}, rd);
      tw = cyc;
      #1;
      chk("modReset pulse", 32'h1, {31'h0, modReset_q});
      chk("rdyN restart", 32'h1, {31'h0, rdyN_q});
      @(posedge mclk);
      #1;
      chk("modReset end", 32'h0, {31'h0, modReset_q});
      @(posedge mclk);
      ahb(1'b0, `SDF_OFF_STAT, 32'h0, rd);
      chk("status restart", 32'h0, rd);
      ahb(1'b0, `SDF_OFF_CTRL, 32'h0, rd);
      chk("ctrl readback", {16'h0, cfg[i]}, rd);
      wait_rdy(1'b0, t1);
      e = exp_first(cfg[i]);
      chk_rng("settling", e - 1, e + 4, t1 - tw);
      ahb(1'b0, `SDF_OFF_DATA, 32'h0, rd);
      if (!cfg[i][12]) chk("result", inLevel ? 32'h1 : 32'hffffffff, rd);
      ahb(1'b0, `SDF_OFF_STAT, 32'h0, rd);
      chk("settled", 32'h2, rd & 32'h2);
      wait_rdy(1'b1, t2);
      wait_rdy(1'b0, t2);
      e = exp_per(cfg[i]);
      chk_rng("period", e - 2, e + 2, t2 - t1);
      chk("chop swap", {31'h0, cfg[i][11]}, {31'h0, chopSwap_q});
      ahb(1'b0, `SDF_OFF_DATA, 32'h0, rd);
      if (!cfg[i][12]) chk("result 2", inLevel ? 32'h1 : 32'hffffffff, rd);
      $display("test config %h done", cfg[i]);
    end
    inLevel <= 1'b1;
    ahb(1'b1, `SDF_OFF_CTRL, 32'h1, rd);
    repeat (4096 + 9 * 1024) @(posedge mclk);
    ahb(1'b0, `SDF_OFF_STAT, 32'h0, rd);
    chk("status full", 32'hc3, rd);
    repeat (8) begin
      ahb(1'b0, `SDF_OFF_DATA, 32'h0, rd);
      chk("drain", 32'h1, rd);
    end
    ahb(1'b0, `SDF_OFF_STAT, 32'h0, rd);
    chk("status empty", 32'h2, rd);
    $display("test fifo done");
    stop_test();
  end
endmodule : tb_sdf_decim_filter
